// file: rtl/host_to_dsp_byte_port.sv
// module: host-to-dsp byte port of the parallel host interface
`timescale 1ns/1ps
module host_to_dsp_byte_port
   import host_port_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hostEnableStrobe_n,
   input wire logic hostReadWriteSelect,
   input wire logic [2:0] hostRegisterSelect,
   input wire logic [7:0] hostDataIn,
   output logic [7:0] hostDataOut,
   output logic hostDataOe,
   input wire logic hostAcknowledgeStrobe_n,
   output logic hostServiceRequest_n,
   output logic hostServiceRequestOe,
   input wire logic dspEnable,
   input wire logic dspRxIrqEnable,
   input wire logic dspRxRead,
   output logic [WIDTH-1:0] dspRxWord,
   output logic dspRxFullFlag,
   input wire logic dspCmdAccept,
   output host_port_pkg::dsp_exception_t dspException,
   output logic semaphoreFlagZero
);
   import host_port_pkg::*;

   // three byte registers make the word, so no other width can be served
   if (WIDTH != 24) begin : g_bad_width
      $error("word width must be three bytes");
   end

   // ----------------------------------------------------------------
   // strobe capture
   // ----------------------------------------------------------------
   logic strobeDly;
   logic strobeRise;
   logic strobeFall;
   host_access_t acc;
   always_comb begin
      strobeRise = hostEnableStrobe_n && !strobeDly;
      strobeFall = !hostEnableStrobe_n && strobeDly;
      acc.sel = hostRegisterSelect;
      acc.data = hostDataIn;
      acc.readNotWrite = hostReadWriteSelect;
   end

   // ----------------------------------------------------------------
   // host registers and flags
   // ----------------------------------------------------------------
   logic [7:0] txHigh;
   logic [7:0] txMiddle;
   logic [7:0] txLow;
   logic txEmpty;
   logic txReqEn;
   logic [1:0] modeBits;
   logic initBit;
   logic cmdPending;
   logic [CMD_VEC_W-1:0] cmdVector;
   logic [7:0] irqVector;
   logic [7:0] next_txHigh;
   logic [7:0] next_txMiddle;
   logic [7:0] next_txLow;
   logic next_txEmpty;
   logic next_txReqEn;
   logic [1:0] next_modeBits;
   logic next_initBit;
   logic next_cmdPending;
   logic [CMD_VEC_W-1:0] next_cmdVector;
   logic [7:0] next_irqVector;
   logic next_sema;
   logic hostWrite;
   logic fifoInReady;
   logic fifoOutValid;
   logic [WIDTH-1:0] fifoOutData;
   logic pushWord;
   logic popWord;
   logic [7:0] statusByte;
   logic reqActive;

   always_comb begin
      hostWrite = strobeRise && !acc.readNotWrite && dspEnable;
      next_txHigh = txHigh;
      next_txMiddle = txMiddle;
      next_txLow = txLow;
      next_txEmpty = txEmpty;
      next_txReqEn = txReqEn;
      next_modeBits = modeBits;
      next_initBit = 1'b0;
      next_cmdPending = cmdPending;
      next_cmdVector = cmdVector;
      next_irqVector = irqVector;
      next_sema = semaphoreFlagZero;
      pushWord = 1'b0;
      if (hostWrite) begin
         case (acc.sel)
            SEL_CONTROL: begin
               next_txReqEn = acc.data[CTL_TX_REQ_EN_BIT];
               next_sema = acc.data[CTL_SEMA0_BIT];
               next_modeBits = {acc.data[CTL_MODE1_BIT], acc.data[CTL_MODE0_BIT]};
               next_initBit = acc.data[CTL_INIT_BIT];
            end
            SEL_CMD_VECTOR: begin
               next_cmdPending = acc.data[CMD_PENDING_BIT];
               next_cmdVector = acc.data[CMD_VEC_W-1:0];
            end
            SEL_IRQ_VECTOR: next_irqVector = acc.data;
            SEL_TX_HIGH: next_txHigh = acc.data;
            SEL_TX_MIDDLE: next_txMiddle = acc.data;
            SEL_TX_LOW: begin
               next_txLow = acc.data;
               next_txEmpty = 1'b0;
            end
            default: ;
         endcase
      end
      // byte buffer moves on as soon as there is room toward the dsp side
      if (!txEmpty && fifoInReady) begin
         pushWord = 1'b1;
         next_txEmpty = 1'b1;
      end
      if (dspCmdAccept) begin
         next_cmdPending = 1'b0;
      end
      if (initBit) begin
         next_txEmpty = 1'b1;
         next_cmdPending = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeDly <= 1'b1;
         txHigh <= 8'h00;
         txMiddle <= 8'h00;
         txLow <= 8'h00;
         txEmpty <= 1'b1;
         txReqEn <= 1'b0;
         modeBits <= 2'h0;
         initBit <= 1'b0;
         cmdPending <= 1'b0;
         cmdVector <= CMD_VEC_RESET;
         irqVector <= IRQ_VEC_RESET;
         semaphoreFlagZero <= 1'b0;
      end else begin
         strobeDly <= hostEnableStrobe_n;
         txHigh <= next_txHigh;
         txMiddle <= next_txMiddle;
         txLow <= next_txLow;
         txEmpty <= next_txEmpty;
         txReqEn <= next_txReqEn;
         modeBits <= next_modeBits;
         initBit <= next_initBit;
         cmdPending <= next_cmdPending;
         cmdVector <= next_cmdVector;
         irqVector <= next_irqVector;
         semaphoreFlagZero <= next_sema;
      end
   end

   // ----------------------------------------------------------------
   // word buffer toward the dsp side
   // ----------------------------------------------------------------
   word_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(pushWord),
      .inReady(fifoInReady),
      .inData({txHigh, txMiddle, txLow}),
      .outValid(fifoOutValid),
      .outReady(popWord),
      .outData(fifoOutData)
   );

   // ----------------------------------------------------------------
   // dsp receive word, exceptions, host request and host read data
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] next_rxWord;
   logic next_rxFull;
   dsp_exception_t next_exc;
   logic [7:0] next_dataOut;
   logic next_dataOe;
   logic next_req_n;
   logic next_reqOe;

   always_comb begin
      next_rxWord = dspRxWord;
      next_rxFull = dspRxFullFlag;
      popWord = 1'b0;
      if (dspRxRead && dspRxFullFlag) begin
         next_rxFull = 1'b0;
      end
      // receive word refills only after it has been emptied
      if (!dspRxFullFlag && fifoOutValid) begin
         popWord = 1'b1;
         next_rxWord = fifoOutData;
         next_rxFull = 1'b1;
      end
      if (initBit) begin
         next_rxFull = 1'b0;
      end
      next_exc.rxIrq = dspRxIrqEnable && next_rxFull;
      next_exc.cmdIrq = next_cmdPending && modeBits == 2'h0;
      if (next_exc.rxIrq) begin
         next_exc.vector = RX_IRQ_VECTOR;
      end else begin
         next_exc.vector = {10'h000, next_cmdVector, 1'b0};
      end
      // request whenever the byte buffer is empty, request is enabled and dspEnable is high, in any mode; acknowledge low drops it
      reqActive = next_txEmpty && next_txReqEn && dspEnable
         && hostAcknowledgeStrobe_n;
      next_req_n = !reqActive;
      next_reqOe = reqActive;
      statusByte = 8'h00;
      statusByte[STS_TX_EMPTY_BIT] = txEmpty;
      statusByte[STS_REQ_BIT] = !hostServiceRequest_n;
      next_dataOe = hostDataOe;
      next_dataOut = hostDataOut;
      if (strobeFall && acc.readNotWrite && dspEnable) begin
         next_dataOe = 1'b1;
         case (acc.sel)
            SEL_CONTROL: next_dataOut = {initBit, modeBits, 1'b0, semaphoreFlagZero,
               1'b0, txReqEn, 1'b0};
            SEL_CMD_VECTOR: next_dataOut = {cmdPending, 2'h0, cmdVector};
            SEL_STATUS: next_dataOut = statusByte;
            SEL_IRQ_VECTOR: next_dataOut = irqVector;
            SEL_TX_HIGH: next_dataOut = txHigh;
            SEL_TX_MIDDLE: next_dataOut = txMiddle;
            SEL_TX_LOW: next_dataOut = txLow;
            default: next_dataOut = 8'h00;
         endcase
      end else if (strobeRise) begin
         next_dataOe = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dspRxWord <= '0;
         dspRxFullFlag <= 1'b0;
         dspException <= '0;
         hostDataOut <= 8'h00;
         hostDataOe <= 1'b0;
         hostServiceRequest_n <= 1'b1;
         hostServiceRequestOe <= 1'b0;
      end else begin
         dspRxWord <= next_rxWord;
         dspRxFullFlag <= next_rxFull;
         dspException <= next_exc;
         hostDataOut <= next_dataOut;
         hostDataOe <= next_dataOe;
         hostServiceRequest_n <= next_req_n;
         hostServiceRequestOe <= next_reqOe;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_lowClears;
      @(posedge clk) disable iff (!rst_n)
      (hostWrite && acc.sel == SEL_TX_LOW && !initBit) |=> !txEmpty;
   endproperty
   a_lowClears: assert property (p_lowClears) else $error("low byte write did not clear");

   property p_txMoves;
      @(posedge clk) disable iff (!rst_n)
      (!txEmpty && fifoInReady) |=> txEmpty;
   endproperty
   a_txMoves: assert property (p_txMoves) else $error("byte buffer not moved");

   property p_reqGate;
      @(posedge clk) disable iff (!rst_n)
      !txReqEn |-> hostServiceRequest_n && !hostServiceRequestOe;
   endproperty
   a_reqGate: assert property (p_reqGate) else $error("masked request reached pin");

   property p_reqAck;
      @(posedge clk) disable iff (!rst_n)
      !hostAcknowledgeStrobe_n |=> hostServiceRequest_n && !hostServiceRequestOe;
   endproperty
   a_reqAck: assert property (p_reqAck) else $error("request held during acknowledge");

   property p_reqAsserts;
      @(posedge clk) disable iff (!rst_n)
      (txEmpty && txReqEn && dspEnable && hostAcknowledgeStrobe_n && !hostWrite)
         |=> !hostServiceRequest_n;
   endproperty
   a_reqAsserts: assert property (p_reqAsserts) else $error("request not raised");

   property p_rxLoad;
      @(posedge clk) disable iff (!rst_n)
      (!dspRxFullFlag && fifoOutValid && !initBit) |=> dspRxFullFlag
         && dspRxWord == $past(fifoOutData);
   endproperty
   a_rxLoad: assert property (p_rxLoad) else $error("receive word not loaded");

   property p_rxClear;
      @(posedge clk) disable iff (!rst_n)
      (dspRxRead && dspRxFullFlag) |=> !dspRxFullFlag;
   endproperty
   a_rxClear: assert property (p_rxClear) else $error("receive flag not cleared");

   property p_rxIrq;
      @(posedge clk) disable iff (!rst_n)
      dspException.rxIrq |-> dspException.vector == RX_IRQ_VECTOR && dspRxFullFlag;
   endproperty
   a_rxIrq: assert property (p_rxIrq) else $error("receive exception wrong");

   property p_cmdVec;
      @(posedge clk) disable iff (!rst_n)
      (dspException.cmdIrq && !dspException.rxIrq)
         |-> dspException.vector == {10'h000, cmdVector, 1'b0};
   endproperty
   a_cmdVec: assert property (p_cmdVec) else $error("command vector not doubled");

   property p_cmdAccept;
      @(posedge clk) disable iff (!rst_n)
      dspCmdAccept |=> !cmdPending;
   endproperty
   a_cmdAccept: assert property (p_cmdAccept) else $error("command bit not cleared");

   property p_initSelfClear;
      @(posedge clk) disable iff (!rst_n)
      initBit |=> !initBit ##0 txEmpty;
   endproperty
   a_initSelfClear: assert property (p_initSelfClear) else $error("init not executed");
endmodule : host_to_dsp_byte_port

// file: common/host_port_pkg.sv
// package: constants and carriers for the host-to-dsp byte port
package host_port_pkg;
   // host-side register selects (3-bit address)
   localparam logic [2:0] SEL_CONTROL = 3'h0;
   localparam logic [2:0] SEL_CMD_VECTOR = 3'h1;
   localparam logic [2:0] SEL_STATUS = 3'h2;
   localparam logic [2:0] SEL_IRQ_VECTOR = 3'h3;
   localparam logic [2:0] SEL_UNUSED = 3'h4;
   localparam logic [2:0] SEL_TX_HIGH = 3'h5;
   localparam logic [2:0] SEL_TX_MIDDLE = 3'h6;
   localparam logic [2:0] SEL_TX_LOW = 3'h7;
   // host control byte fields
   localparam int CTL_TX_REQ_EN_BIT = 1;
   localparam int CTL_SEMA0_BIT = 3;
   localparam int CTL_MODE0_BIT = 5;
   localparam int CTL_MODE1_BIT = 6;
   localparam int CTL_INIT_BIT = 7;
   // command vector byte fields
   localparam int CMD_PENDING_BIT = 7;
   localparam int CMD_VEC_W = 5;
   // host status byte fields
   localparam int STS_TX_EMPTY_BIT = 1;
   localparam int STS_REQ_BIT = 7;
   // reset values, vectors and sizes
   localparam logic [4:0] CMD_VEC_RESET = 5'h12;
   localparam logic [15:0] RX_IRQ_VECTOR = 16'h0020;
   localparam logic [7:0] IRQ_VEC_RESET = 8'h0F;
   localparam int WORD_W = 24;
   localparam int FIFO_DEPTH = 32;

   typedef struct packed {
      logic [2:0] sel;
      logic [7:0] data;
      logic readNotWrite;
   } host_access_t;

   typedef struct packed {
      logic rxIrq;
      logic cmdIrq;
      logic [15:0] vector;
   } dsp_exception_t;
endpackage : host_port_pkg

// file: rtl/word_fifo.sv
// module: synchronous valid/ready fifo
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   // pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("word_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   logic [AW:0] next_wrPtr;
   logic [AW:0] next_rdPtr;
   logic doWrite;
   logic doRead;

   always_comb begin
      inReady = (wrPtr - rdPtr) != (AW + 1)'(DEPTH);
      outValid = wrPtr != rdPtr;
      outData = mem[rdPtr[AW-1:0]];
      doWrite = inValid && inReady;
      doRead = outValid && outReady;
      next_wrPtr = wrPtr + (AW + 1)'(doWrite);
      next_rdPtr = rdPtr + (AW + 1)'(doRead);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
      end
   end

   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule : word_fifo

// file: bench/host_model.sv
// host processor model driving the parallel strobe port
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   output logic hostEnableStrobe_n,
   output logic hostReadWriteSelect,
   output logic [2:0] hostRegisterSelect,
   output logic [7:0] hostDataIn,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOe,
   output logic hostAcknowledgeStrobe_n
);
   initial begin
      hostEnableStrobe_n = 1'h1;
      hostReadWriteSelect = 1'h1;
      hostRegisterSelect = 3'h4;
      hostDataIn = 8'h5A;
      hostAcknowledgeStrobe_n = 1'h1;
   end

   task automatic host_write(input logic [2:0] sel, input logic [7:0] data);
      @(negedge clk);
      hostReadWriteSelect = 1'h0;
      hostRegisterSelect = sel;
      hostDataIn = data;
      hostEnableStrobe_n = 1'h0;
      @(negedge clk);
      hostEnableStrobe_n = 1'h1;
      @(negedge clk);
      // held over the edge that sees the rise; then no stale value left on the bus
      hostDataIn = ~data;
   endtask : host_write

   task automatic host_read(input logic [2:0] sel, output logic [7:0] data);
      @(negedge clk);
      hostReadWriteSelect = 1'h1;
      hostRegisterSelect = sel;
      hostEnableStrobe_n = 1'h0;
      repeat (2) @(negedge clk);
      // undriven bus must never pass as data
      data = (hostDataOe === 1'h1) ? hostDataOut : 8'hXX;
      hostEnableStrobe_n = 1'h1;
   endtask : host_read

   task automatic set_ack(input logic level);
      @(negedge clk);
      hostAcknowledgeStrobe_n = level;
   endtask : set_ack
endmodule : host_model

// file: bench/tb_top.sv
// self-checking bench for the host-to-dsp byte port
`timescale 1ns/1ps
module tb_top;
   import host_port_pkg::*;
   logic clk, rst_n, strobe_n, rdWr, dataOe, ack_n, reqOut_n, reqOe;
   logic dspEnable, dspRxIrqEnable, dspRxRead, dspCmdAccept, dspRxFullFlag, sema;
   logic [2:0] regSel;
   logic [7:0] dIn, dOut, rd;
   logic [23:0] dspRxWord;
   dsp_exception_t dspException;
   int nErrors = 0;
   int cmpCount = 0;
   int cycles = 0;
   int n, i, v;
   logic stop;

   host_to_dsp_byte_port host_to_dsp_byte_port_inst (
      .clk(clk), .rst_n(rst_n), .hostEnableStrobe_n(strobe_n),
      .hostReadWriteSelect(rdWr), .hostRegisterSelect(regSel), .hostDataIn(dIn),
      .hostDataOut(dOut), .hostDataOe(dataOe), .hostAcknowledgeStrobe_n(ack_n),
      .hostServiceRequest_n(reqOut_n), .hostServiceRequestOe(reqOe),
      .dspEnable(dspEnable), .dspRxIrqEnable(dspRxIrqEnable), .dspRxRead(dspRxRead),
      .dspRxWord(dspRxWord), .dspRxFullFlag(dspRxFullFlag), .dspCmdAccept(dspCmdAccept),
      .dspException(dspException), .semaphoreFlagZero(sema));

   host_model host_model_inst (
      .clk(clk), .hostEnableStrobe_n(strobe_n), .hostReadWriteSelect(rdWr),
      .hostRegisterSelect(regSel), .hostDataIn(dIn), .hostDataOut(dOut),
      .hostDataOe(dataOe), .hostAcknowledgeStrobe_n(ack_n));

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // compare, closing and dsp-side tasks
   // ---------------------------------------------------------------
   task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
      cmpCount++;
      if (got !== exp) begin
         nErrors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      check_word({16'h0000, got}, {16'h0000, exp});
   endtask : check_byte

   task automatic check_bit(input logic got, input logic exp);
      check_word({23'h000000, got}, {23'h000000, exp});
   endtask : check_bit

   task automatic complete_run;
      $display("comparisons %0d errors %0d", cmpCount, nErrors);
      if (nErrors == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic wait_full;
      int k;
      k = 0;
      while (dspRxFullFlag !== 1'h1 && k < 20) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_full

   task automatic dsp_read;
      @(negedge clk);
      dspRxRead = 1'h1;
      @(negedge clk);
      dspRxRead = 1'h0;
   endtask : dsp_read

   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         nErrors++;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'h0;
      dspEnable = 1'h0;
      dspRxIrqEnable = 1'h0;
      dspRxRead = 1'h0;
      dspCmdAccept = 1'h0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'h1;
      check_bit(reqOut_n, 1'h1);
      check_bit(reqOe, 1'h0);
      check_bit(dspRxFullFlag, 1'h0);
      check_word({6'h00, dspException}, 24'h000000);
      // a write before the dsp side enables the port is ignored
      host_model_inst.host_write(SEL_IRQ_VECTOR, 8'h33);
      dspEnable = 1'h1;
      host_model_inst.host_read(SEL_CMD_VECTOR, rd);
      check_byte(rd & 8'h9F, 8'h12);
      host_model_inst.host_write(SEL_CMD_VECTOR, 8'h12);
      host_model_inst.host_read(SEL_IRQ_VECTOR, rd);
      check_byte(rd, IRQ_VEC_RESET);
      host_model_inst.host_write(SEL_UNUSED, 8'hFF);
      host_model_inst.host_read(SEL_UNUSED, rd);
      check_byte(rd, 8'h00);
      host_model_inst.host_read(SEL_STATUS, rd);
      check_bit(rd[STS_TX_EMPTY_BIT], 1'h1);
      check_bit(rd[STS_REQ_BIT], 1'h0);
      check_bit(reqOut_n, 1'h1);
      host_model_inst.host_write(SEL_CONTROL, 8'h02);
      repeat (3) @(negedge clk);
      check_bit(reqOut_n, 1'h0);
      check_bit(reqOe, 1'h1);
      host_model_inst.host_read(SEL_STATUS, rd);
      check_bit(rd[STS_REQ_BIT], 1'h1);
      host_model_inst.set_ack(1'h0);
      repeat (3) @(negedge clk);
      check_bit(reqOut_n, 1'h1);
      host_model_inst.set_ack(1'h1);
      repeat (3) @(negedge clk);
      check_bit(reqOut_n, 1'h0);
      host_model_inst.host_write(SEL_CONTROL, 8'h00);
      repeat (3) @(negedge clk);
      check_bit(reqOut_n, 1'h1);
      // full word, then low only, then middle and low
      dspRxIrqEnable = 1'h1;
      host_model_inst.host_write(SEL_TX_HIGH, 8'hA1);
      host_model_inst.host_write(SEL_TX_MIDDLE, 8'hB2);
      host_model_inst.host_write(SEL_TX_LOW, 8'hC3);
      wait_full();
      check_bit(dspRxFullFlag, 1'h1);
      check_word(dspRxWord, 24'hA1B2C3);
      check_bit(dspException.rxIrq, 1'h1);
      check_word({8'h00, dspException.vector}, {8'h00, RX_IRQ_VECTOR});
      dsp_read();
      check_bit(dspRxFullFlag, 1'h0);
      check_bit(dspException.rxIrq, 1'h0);
      host_model_inst.host_write(SEL_TX_LOW, 8'h44);
      wait_full();
      check_word(dspRxWord, 24'hA1B244);
      dsp_read();
      host_model_inst.host_write(SEL_TX_MIDDLE, 8'h77);
      host_model_inst.host_write(SEL_TX_LOW, 8'h88);
      wait_full();
      check_word(dspRxWord, 24'hA17788);
      dsp_read();
      dspRxIrqEnable = 1'h0;
      // host commands, default vector included
      for (i = 0; i < 3; i++) begin
         v = (i == 0) ? 'h12 : (i == 1) ? 'h05 : 'h1F;
         host_model_inst.host_write(SEL_CMD_VECTOR, {3'h4, v[4:0]});
         repeat (3) @(negedge clk);
         check_bit(dspException.cmdIrq, 1'h1);
         check_word({8'h00, dspException.vector}, {13'h0000, v[4:0], 6'h00} >> 5);
         dspCmdAccept = 1'h1;
         @(negedge clk);
         dspCmdAccept = 1'h0;
         host_model_inst.host_read(SEL_CMD_VECTOR, rd);
         check_byte(rd & 8'h9F, {3'h0, v[4:0]});
         check_bit(dspException.cmdIrq, 1'h0);
      end
      // a transfer mode other than polling or interrupt holds the command back
      host_model_inst.host_write(SEL_CONTROL, 8'h20);
      host_model_inst.host_write(SEL_CMD_VECTOR, 8'h85);
      repeat (3) @(negedge clk);
      check_bit(dspException.cmdIrq, 1'h0);
      host_model_inst.host_read(SEL_CONTROL, rd);
      check_byte(rd, 8'h20);
      host_model_inst.host_write(SEL_CMD_VECTOR, 8'h05);
      host_model_inst.host_write(SEL_CONTROL, 8'h0A);
      repeat (2) @(negedge clk);
      check_bit(sema, 1'h1);
      // fill the word buffer by polling while the dsp stalls
      n = 0;
      stop = 1'h0;
      while (!stop && n < 40) begin
         host_model_inst.host_read(SEL_STATUS, rd);
         if (rd[STS_TX_EMPTY_BIT] === 1'h1) begin
            host_model_inst.host_write(SEL_TX_LOW, n[7:0]);
            n++;
         end else begin
            stop = 1'h1;
         end
      end
      check_bit(n >= FIFO_DEPTH && n < 40, 1'h1);
      check_bit(reqOut_n, 1'h1);
      host_model_inst.host_read(SEL_STATUS, rd);
      check_bit(rd[STS_TX_EMPTY_BIT], 1'h0);
      for (i = 0; i < n; i++) begin
         wait_full();
         check_word(dspRxWord, {16'hA177, i[7:0]});
         repeat (2) @(negedge clk);
         dsp_read();
      end
      repeat (5) @(negedge clk);
      check_bit(dspRxFullFlag, 1'h0);
      check_bit(reqOut_n, 1'h0);
      // initialization command with a word waiting
      host_model_inst.host_write(SEL_TX_LOW, 8'h5A);
      wait_full();
      host_model_inst.host_write(SEL_CONTROL, 8'h82);
      repeat (2) @(negedge clk);
      check_bit(dspRxFullFlag, 1'h0);
      host_model_inst.host_read(SEL_CONTROL, rd);
      check_bit(rd[CTL_INIT_BIT], 1'h0);
      host_model_inst.host_read(SEL_STATUS, rd);
      check_bit(rd[STS_TX_EMPTY_BIT], 1'h1);
      // reset in mid-run restores the vector field and drops the request
      host_model_inst.host_write(SEL_CMD_VECTOR, 8'h03);
      @(negedge clk);
      rst_n = 1'h0;
      #1;
      check_bit(reqOut_n, 1'h1);
      @(negedge clk);
      rst_n = 1'h1;
      host_model_inst.host_read(SEL_CMD_VECTOR, rd);
      check_byte(rd & 8'h9F, 8'h12);
      check_bit(reqOut_n, 1'h1);
      complete_run();
   end
endmodule : tb_top
